/* design/sfd_pkg.sv */
// Constants and types for the set-features command decoder
// How it works
// - Opcode EFh; feature code selects parameter
// - Undefined feature code aborts, state unchanged
// - 02h/82h cache; reassign full forces off
// - Code 03h: count gives type and mode
// - Legal transfer types and mode ranges
// - 05h enables power management, 85h disables
// - Level decode: abort, idle, low-power, low-rpm
// - Low-power delay (x-80h)*5+120 seconds
// - Low-rpm delay (x-40h)*60+600, else 600
// - Low-rpm keeps set delay, else 120
// - Power state persists; soft reset rule
// - 06h/86h standby power-up, 07h spin-up
// - 10h/90h switch named serial link feature
// - 55h disables, AAh enables look-ahead
// - 66h disables, CCh enables soft-reset revert
// - Hard reset defaults cache, look-ahead, revert
// - Zero sector time means full rate
package sfd_pkg;
  // Register byte offsets
  localparam logic [7:0] ADR_FEATURE = 8'h00;
  localparam logic [7:0] ADR_SCOUNT = 8'h04;
  localparam logic [7:0] ADR_LBA_LO = 8'h08;
  localparam logic [7:0] ADR_LBA_MID = 8'h0C;
  localparam logic [7:0] ADR_LBA_HI = 8'h10;
  localparam logic [7:0] ADR_COMMAND = 8'h14;
  localparam logic [7:0] ADR_ERROR = 8'h18;
  localparam logic [7:0] ADR_STATUS = 8'h1C;
  localparam logic [7:0] ADR_FEAT_STATE = 8'h20;
  localparam logic [7:0] ADR_XFER = 8'h24;
  localparam logic [7:0] ADR_APM = 8'h28;
  localparam logic [7:0] ADR_DELAY1 = 8'h2C;
  localparam logic [7:0] ADR_DELAY2 = 8'h30;
  localparam logic [7:0] ADR_SECT_TIME = 8'h34;
  localparam logic [7:0] ADR_CONTROL = 8'h38;
  // Opcode and feature codes
  localparam logic [7:0] OP_SET_FEATURES = 8'hEF;
  localparam logic [7:0] FC_WC_ON = 8'h02;
  localparam logic [7:0] FC_XFER = 8'h03;
  localparam logic [7:0] FC_APM_ON = 8'h05;
  localparam logic [7:0] FC_PUIS_ON = 8'h06;
  localparam logic [7:0] FC_SPINUP = 8'h07;
  localparam logic [7:0] FC_SATA_ON = 8'h10;
  localparam logic [7:0] FC_SECT_TIME = 8'h43;
  localparam logic [7:0] FC_RLA_OFF = 8'h55;
  localparam logic [7:0] FC_REVERT_OFF = 8'h66;
  localparam logic [7:0] FC_WC_OFF = 8'h82;
  localparam logic [7:0] FC_APM_OFF = 8'h85;
  localparam logic [7:0] FC_PUIS_OFF = 8'h86;
  localparam logic [7:0] FC_SATA_OFF = 8'h90;
  localparam logic [7:0] FC_RLA_ON = 8'hAA;
  localparam logic [7:0] FC_REVERT_ON = 8'hCC;
  // Transfer types (upper five bits of the count)
  localparam logic [4:0] XT_PIO_DEF = 5'h00;
  localparam logic [4:0] XT_PIO_FC = 5'h01;
  localparam logic [4:0] XT_MWDMA = 5'h04;
  localparam logic [4:0] XT_UDMA = 5'h08;
  localparam logic [2:0] XM_PIO_DEF_MAX = 3'h1;
  localparam logic [2:0] XM_PIO_FC_MAX = 3'h4;
  localparam logic [2:0] XM_MWDMA_MAX = 3'h2;
  localparam logic [2:0] XM_UDMA_MAX = 3'h6;
  // Power management level bounds and delay arithmetic, seconds
  localparam logic [7:0] LVL_IDLE_MIN = 8'hC0;
  localparam logic [7:0] LVL_LPI_MIN = 8'h80;
  localparam logic [7:0] LVL_LRPM_MIN = 8'h40;
  localparam logic [8:0] LPI_STEP_S = 9'h005;
  localparam logic [8:0] LPI_BASE_S = 9'h078;
  localparam logic [12:0] LRPM_STEP_S = 13'h003C;
  localparam logic [12:0] LRPM_BASE_S = 13'h0258;
  // Register bit positions
  localparam int ERR_ABT_BIT = 2;
  localparam int ST_BSY_BIT = 7;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_ERR_BIT = 0;
  localparam int CTL_REASSIGN_BIT = 0;
  localparam int CTL_SOFTRST_BIT = 1;
  localparam int CTL_STANDBY_BIT = 2;
  // Values after hard reset
  localparam logic RST_WCACHE = 1'b1;
  localparam logic RST_RLA = 1'b1;
  localparam logic RST_REVERT = 1'b0;
  localparam logic [7:0] RST_XFER = 8'h00;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    APM_OFF = 2'b00,
    APM_IDLE = 2'b01,
    APM_LPI = 2'b10,
    APM_LRPM = 2'b11
  } sfd_apm_e;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } sfd_state_e;
endpackage : sfd_pkg

/* design/sfd_apm_decode.sv */
// Power management level decoder with idle delay arithmetic
`timescale 1ns/1ps
module sfd_apm_decode (
  input wire logic [7:0] level_i, // Level from sector count
  output logic abort_o, // Level not accepted
  output sfd_pkg::sfd_apm_e mode_o, // Deepest saving state
  output logic [8:0] delay1_o, // Low-power idle delay, s
  output logic [12:0] delay2_o // Low-rpm idle delay, s
);
  logic [5:0] ofs_w;
  logic is_lpi_w;
  logic is_idle_w;
  logic is_hi_rpm_w;

  // Range classification
  assign ofs_w = level_i[5:0];
  assign abort_o = (level_i == 8'hFF) || (level_i == 8'h00);
  assign is_idle_w = level_i >= sfd_pkg::LVL_IDLE_MIN;
  assign is_lpi_w = !is_idle_w && level_i >= sfd_pkg::LVL_LPI_MIN;
  assign is_hi_rpm_w = !is_lpi_w && level_i >= sfd_pkg::LVL_LRPM_MIN;
  assign mode_o = is_idle_w ? sfd_pkg::APM_IDLE
                : is_lpi_w ? sfd_pkg::APM_LPI : sfd_pkg::APM_LRPM;

  // Delay arithmetic
  assign delay1_o = is_lpi_w
    ? 9'({3'h0, ofs_w} * sfd_pkg::LPI_STEP_S + sfd_pkg::LPI_BASE_S)
    : sfd_pkg::LPI_BASE_S;
  assign delay2_o = is_hi_rpm_w
    ? 13'({7'h00, ofs_w} * sfd_pkg::LRPM_STEP_S
          + sfd_pkg::LRPM_BASE_S)
    : sfd_pkg::LRPM_BASE_S;
endmodule : sfd_apm_decode

/* design/sfd_set_features.sv */
// Set-features command decoder with AXI4-Lite register access
`timescale 1ns/1ps
module sfd_set_features (
  input wire logic clock_i, // 40 MHz clock
  input wire logic srst_i, // Hard reset, sync, high
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [7:0] s_axi_awaddr, // Write byte address
  input wire logic [2:0] s_axi_awprot, // Unused protection
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte strobes
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  output logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  input wire logic [7:0] s_axi_araddr, // Read byte address
  input wire logic [2:0] s_axi_arprot, // Unused protection
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic write_cache_on_o, // Effective write cache
  output logic look_ahead_on_o, // Read look-ahead enable
  output logic spin_up_o, // One-cycle spin-up request
  output logic busy_o // Command in progress
);
  sfd_pkg::sfd_state_e state_r;
  logic [7:0] feat_r, scnt_r, lba_lo_r, lba_mid_r, lba_hi_r, cmd_r;
  logic abt_r, err_r;
  logic wcache_r, rla_r, revert_r, puis_r;
  logic [7:0] sata_r;
  logic [7:0] xfer_r;
  sfd_pkg::sfd_apm_e apm_mode_r;
  logic [7:0] apm_lvl_r;
  logic [8:0] delay1_r;
  logic delay1_set_r;
  logic [12:0] delay2_r;
  logic [15:0] pio_time_r, dma_time_r;
  logic reassign_full_r, standby_r, soft_req_r;
  logic wc_eff_r, spin_r;
  logic bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic wr_w, rd_w, exec_w, abort_w, apm_abort_w, xfer_ok_w, sata_ok_w;
  logic wr_lo_w, wr_map_w, rd_map_w, start_w, soft_w;
  sfd_pkg::sfd_apm_e apm_mode_w;
  logic [8:0] apm_d1_w;
  logic [12:0] apm_d2_w;
  logic [31:0] rd_mux_w;
  logic [7:0] status_w, error_w, feat_state_w;

  // Level and delay decode of the sector count
  sfd_apm_decode u_apm (
    .level_i(scnt_r),
    .abort_o(apm_abort_w),
    .mode_o(apm_mode_w),
    .delay1_o(apm_d1_w),
    .delay2_o(apm_d2_w)
  );

  // Legal transfer type and mode pairs
  function automatic logic xfer_legal(input logic [7:0] sel);
    logic [4:0] kind;
    logic [2:0] mode;
    kind = sel[7:3];
    mode = sel[2:0];
    case (kind)
      sfd_pkg::XT_PIO_DEF: xfer_legal = mode <= sfd_pkg::XM_PIO_DEF_MAX;
      sfd_pkg::XT_PIO_FC: xfer_legal = mode <= sfd_pkg::XM_PIO_FC_MAX;
      sfd_pkg::XT_MWDMA: xfer_legal = mode <= sfd_pkg::XM_MWDMA_MAX;
      sfd_pkg::XT_UDMA: xfer_legal = mode <= sfd_pkg::XM_UDMA_MAX;
      default: xfer_legal = 1'b0;
    endcase
  endfunction : xfer_legal

  // Bus handshakes and address decode
  assign wr_w = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rd_w = s_axi_arvalid && !rvalid_r;
  assign s_axi_awready = wr_w;
  assign s_axi_wready = wr_w;
  assign s_axi_arready = rd_w;
  assign wr_lo_w = wr_w && s_axi_wstrb[0];
  assign wr_map_w = s_axi_awaddr <= sfd_pkg::ADR_CONTROL
                    && s_axi_awaddr[1:0] == 2'h0;
  assign rd_map_w = s_axi_araddr <= sfd_pkg::ADR_CONTROL
                    && s_axi_araddr[1:0] == 2'h0;
  assign start_w = wr_lo_w && s_axi_awaddr == sfd_pkg::ADR_COMMAND
                   && state_r == sfd_pkg::ST_IDLE;
  assign soft_w = wr_lo_w && s_axi_awaddr == sfd_pkg::ADR_CONTROL
                  && s_axi_wdata[sfd_pkg::CTL_SOFTRST_BIT];
  assign exec_w = state_r == sfd_pkg::ST_EXEC;

  // Feature code and parameter check
  assign xfer_ok_w = xfer_legal(scnt_r);
  assign sata_ok_w = scnt_r inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h06};
  always_comb begin
    if (cmd_r != sfd_pkg::OP_SET_FEATURES) begin
      abort_w = 1'b1;
    end else begin
      case (feat_r)
        sfd_pkg::FC_WC_ON, sfd_pkg::FC_WC_OFF: abort_w = 1'b0;
        sfd_pkg::FC_XFER: abort_w = !xfer_ok_w;
        sfd_pkg::FC_APM_ON: abort_w = apm_abort_w;
        sfd_pkg::FC_APM_OFF, sfd_pkg::FC_PUIS_ON: abort_w = 1'b0;
        sfd_pkg::FC_PUIS_OFF, sfd_pkg::FC_SECT_TIME: abort_w = 1'b0;
        sfd_pkg::FC_SPINUP: abort_w = !puis_r;
        sfd_pkg::FC_SATA_ON, sfd_pkg::FC_SATA_OFF: abort_w = !sata_ok_w;
        sfd_pkg::FC_RLA_ON, sfd_pkg::FC_RLA_OFF: abort_w = 1'b0;
        sfd_pkg::FC_REVERT_ON, sfd_pkg::FC_REVERT_OFF: abort_w = 1'b0;
        default: abort_w = 1'b1;
      endcase
    end
  end

  // Command sequencer and parameter latches
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_r <= sfd_pkg::ST_IDLE;
      {feat_r, scnt_r, lba_lo_r, lba_mid_r, lba_hi_r} <= 40'h0;
      cmd_r <= 8'h00;
      abt_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if (wr_lo_w && state_r == sfd_pkg::ST_IDLE) begin
        if (s_axi_awaddr == sfd_pkg::ADR_FEATURE) feat_r <= s_axi_wdata[7:0];
        if (s_axi_awaddr == sfd_pkg::ADR_SCOUNT) scnt_r <= s_axi_wdata[7:0];
        if (s_axi_awaddr == sfd_pkg::ADR_LBA_LO) lba_lo_r <= s_axi_wdata[7:0];
        if (s_axi_awaddr == sfd_pkg::ADR_LBA_MID)
          lba_mid_r <= s_axi_wdata[7:0];
        if (s_axi_awaddr == sfd_pkg::ADR_LBA_HI) lba_hi_r <= s_axi_wdata[7:0];
      end
      if (start_w) begin
        cmd_r <= s_axi_wdata[7:0];
        state_r <= sfd_pkg::ST_EXEC;
        abt_r <= 1'b0;
        err_r <= 1'b0;
      end else if (exec_w) begin
        state_r <= sfd_pkg::ST_IDLE;
        abt_r <= abort_w;
        err_r <= abort_w;
      end
    end
  end

  // Simple feature switches
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wcache_r <= sfd_pkg::RST_WCACHE;
      rla_r <= sfd_pkg::RST_RLA;
      revert_r <= sfd_pkg::RST_REVERT;
      puis_r <= 1'b0;
      sata_r <= 8'h00;
      xfer_r <= sfd_pkg::RST_XFER;
      pio_time_r <= 16'h0000;
      dma_time_r <= 16'h0000;
    end else if (soft_req_r && revert_r) begin
      wcache_r <= sfd_pkg::RST_WCACHE;
      rla_r <= sfd_pkg::RST_RLA;
      xfer_r <= sfd_pkg::RST_XFER;
    end else if (exec_w && !abort_w) begin
      case (feat_r)
        sfd_pkg::FC_WC_ON: wcache_r <= 1'b1;
        sfd_pkg::FC_WC_OFF: wcache_r <= 1'b0;
        sfd_pkg::FC_XFER: xfer_r <= scnt_r;
        sfd_pkg::FC_PUIS_ON: puis_r <= 1'b1;
        sfd_pkg::FC_PUIS_OFF: puis_r <= 1'b0;
        sfd_pkg::FC_SATA_ON: sata_r[scnt_r[2:0]] <= 1'b1;
        sfd_pkg::FC_SATA_OFF: sata_r[scnt_r[2:0]] <= 1'b0;
        sfd_pkg::FC_RLA_OFF: rla_r <= 1'b0;
        sfd_pkg::FC_RLA_ON: rla_r <= 1'b1;
        sfd_pkg::FC_REVERT_OFF: revert_r <= 1'b0;
        sfd_pkg::FC_REVERT_ON: revert_r <= 1'b1;
        sfd_pkg::FC_SECT_TIME: begin
          pio_time_r <= {lba_lo_r, scnt_r};
          dma_time_r <= {lba_hi_r, lba_mid_r};
        end
        default: ;
      endcase
    end
  end

  // Power management state and idle delays
  always_ff @(posedge clock_i) begin
    if (srst_i || (soft_req_r && revert_r)) begin
      apm_mode_r <= sfd_pkg::APM_OFF;
      apm_lvl_r <= 8'h00;
      delay1_r <= 9'h000;
      delay1_set_r <= 1'b0;
      delay2_r <= 13'h0000;
    end else if (exec_w && !abort_w && feat_r == sfd_pkg::FC_APM_OFF) begin
      apm_mode_r <= sfd_pkg::APM_OFF;
      delay1_r <= 9'h000;
      delay1_set_r <= 1'b0;
      delay2_r <= 13'h0000;
    end else if (exec_w && !abort_w && feat_r == sfd_pkg::FC_APM_ON) begin
      apm_mode_r <= apm_mode_w;
      apm_lvl_r <= scnt_r;
      case (apm_mode_w)
        sfd_pkg::APM_LPI: begin
          delay1_r <= apm_d1_w;
          delay1_set_r <= 1'b1;
          delay2_r <= 13'h0000;
        end
        sfd_pkg::APM_LRPM: begin
          delay2_r <= apm_d2_w;
          delay1_set_r <= 1'b1;
          if (!delay1_set_r) delay1_r <= sfd_pkg::LPI_BASE_S;
        end
        default: begin
          delay1_r <= 9'h000;
          delay1_set_r <= 1'b0;
          delay2_r <= 13'h0000;
        end
      endcase
    end
  end

  // Control bits, spin-up pulse and effective cache
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      reassign_full_r <= 1'b0;
      standby_r <= 1'b0;
      soft_req_r <= 1'b0;
      spin_r <= 1'b0;
      wc_eff_r <= sfd_pkg::RST_WCACHE;
    end else begin
      soft_req_r <= soft_w;
      if (wr_lo_w && s_axi_awaddr == sfd_pkg::ADR_CONTROL) begin
        reassign_full_r <= s_axi_wdata[sfd_pkg::CTL_REASSIGN_BIT];
        standby_r <= s_axi_wdata[sfd_pkg::CTL_STANDBY_BIT];
      end else if (spin_r) begin
        standby_r <= 1'b0;
      end
      spin_r <= exec_w && !abort_w && feat_r == sfd_pkg::FC_SPINUP
                && standby_r;
      wc_eff_r <= wcache_r && !reassign_full_r;
    end
  end

  // Read data assembly
  assign status_w = {exec_w, !exec_w, 5'h00, err_r};
  assign error_w = {5'h00, abt_r, 2'h0};
  assign feat_state_w = {2'h0, standby_r, reassign_full_r, puis_r,
                         revert_r, rla_r, wc_eff_r};
  always_comb begin
    case (s_axi_araddr)
      sfd_pkg::ADR_FEATURE: rd_mux_w = {24'h0, feat_r};
      sfd_pkg::ADR_SCOUNT: rd_mux_w = {24'h0, scnt_r};
      sfd_pkg::ADR_LBA_LO: rd_mux_w = {24'h0, lba_lo_r};
      sfd_pkg::ADR_LBA_MID: rd_mux_w = {24'h0, lba_mid_r};
      sfd_pkg::ADR_LBA_HI: rd_mux_w = {24'h0, lba_hi_r};
      sfd_pkg::ADR_COMMAND: rd_mux_w = {24'h0, cmd_r};
      sfd_pkg::ADR_ERROR: rd_mux_w = {24'h0, error_w};
      sfd_pkg::ADR_STATUS: rd_mux_w = {24'h0, status_w};
      sfd_pkg::ADR_FEAT_STATE: rd_mux_w = {16'h0, sata_r, feat_state_w};
      sfd_pkg::ADR_XFER: rd_mux_w = {24'h0, xfer_r};
      sfd_pkg::ADR_APM: rd_mux_w = {22'h0, apm_mode_r, apm_lvl_r};
      sfd_pkg::ADR_DELAY1: rd_mux_w = {22'h0, delay1_set_r, delay1_r};
      sfd_pkg::ADR_DELAY2: rd_mux_w = {19'h0, delay2_r};
      sfd_pkg::ADR_SECT_TIME: rd_mux_w = {dma_time_r, pio_time_r};
      sfd_pkg::ADR_CONTROL: rd_mux_w = {29'h0, standby_r, 1'b0,
                                        reassign_full_r};
      default: rd_mux_w = 32'h0;
    endcase
  end

  // Bus responses
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= sfd_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= sfd_pkg::RESP_OKAY;
      rdata_r <= 32'h0;
    end else begin
      if (wr_w) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_map_w ? sfd_pkg::RESP_OKAY : sfd_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_w) begin
        rvalid_r <= 1'b1;
        rresp_r <= rd_map_w ? sfd_pkg::RESP_OKAY : sfd_pkg::RESP_SLVERR;
        rdata_r <= rd_mux_w;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Output drive
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign write_cache_on_o = wc_eff_r;
  assign look_ahead_on_o = rla_r;
  assign spin_up_o = spin_r;
  assign busy_o = exec_w;

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  undef_abort_a: assert property (exec_w && cmd_r == 8'hEF
    && !(feat_r inside {8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h10, 8'h43,
    8'h55, 8'h66, 8'h82, 8'h85, 8'h86, 8'h90, 8'hAA, 8'hCC})
    |=> abt_r && err_r && $stable(wcache_r) && $stable(xfer_r))
    else $error("undefined feature code not aborted");
  abort_bits_a: assert property (exec_w && abort_w
    |=> !busy_o && status_w == 8'h41 && error_w == 8'h04)
    else $error("abort not reported as error with abort bit only");
  busy_once_a: assert property (start_w |=> busy_o ##1 !busy_o)
    else $error("busy did not clear after one cycle");
  cache_forced_a: assert property (reassign_full_r |=> !write_cache_on_o)
    else $error("write cache on with reassign full");
  lpi_delay_a: assert property (exec_w && !abort_w
    && feat_r == 8'h05 && scnt_r inside {[8'h80:8'hBF]}
    |=> delay1_r == 9'((scnt_r - 8'h80) * 5 + 120) && delay2_r == 13'h0)
    else $error("low-power idle delay wrong");
  lrpm_delay_a: assert property (exec_w && !abort_w
    && feat_r == 8'h05 && scnt_r inside {[8'h40:8'h7F]}
    |=> delay2_r == 13'((scnt_r - 8'h40) * 60 + 600))
    else $error("low-rpm idle delay wrong");
  keep_delay_a: assert property (exec_w && !abort_w && feat_r == 8'h05
    && scnt_r inside {[8'h01:8'h7F]}
    |=> delay1_r == ($past(delay1_set_r) ? $past(delay1_r) : 9'd120))
    else $error("low-power delay not kept or defaulted");
  xfer_take_a: assert property (exec_w && !abort_w && feat_r == 8'h03
    |=> xfer_r == $past(scnt_r) && xfer_r[7:3] inside {5'h0, 5'h1, 5'h4,
    5'h8})
    else $error("transfer selection not taken");
  rst_default_a: assert property ($past(srst_i) |-> wcache_r && rla_r
    && !revert_r)
    else $error("hard reset defaults wrong");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  abort_cov: cover property (exec_w && abort_w);
  lrpm_cov: cover property (exec_w && !abort_w && feat_r == 8'h05
    && apm_mode_w == sfd_pkg::APM_LRPM);
  spin_cov: cover property (spin_up_o);
  revert_cov: cover property (soft_req_r && revert_r);
endmodule : sfd_set_features

/* verification/sfd_host_model.sv */
// Host adapter model: AXI4-Lite master issuing task-file commands
`timescale 1ns/1ps
module sfd_host_model (
  input wire logic clock_i, // Clock
  output logic awvalid_o, // Addr valid
  input wire logic awready_i, // Addr ready
  output logic [7:0] awaddr_o, // Write addr
  output logic wvalid_o, // Data valid
  input wire logic wready_i, // Data ready
  output logic [31:0] wdata_o, // Write data
  input wire logic bvalid_i, // Resp valid
  output logic bready_o, // Resp ready
  input wire logic [1:0] bresp_i, // Write resp
  output logic arvalid_o, // Read addr valid
  input wire logic arready_i, // Read addr ready
  output logic [7:0] araddr_o, // Read addr
  input wire logic rvalid_i, // Read valid
  output logic rready_o, // Read ready
  input wire logic [31:0] rdata_i, // Read data
  input wire logic [1:0] rresp_i // Read resp
);
  int n_cmd = 0; // Commands issued
  // Idle bus at time zero
  initial begin
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
    {awaddr_o, araddr_o, wdata_o} = 48'h0;
  end
  // One write; address and data held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clock_i);
    {awvalid_o, wvalid_o, bready_o} <= 3'h7;
    awaddr_o <= a;
    wdata_o <= d;
    do @(posedge clock_i); while ((awready_i & wready_i) !== 1'b1);
    {awvalid_o, wvalid_o} <= 2'h0;
    awaddr_o <= ~a; // Released lines carry no stale value
    wdata_o <= ~d;
    while (bvalid_i !== 1'b1) @(posedge clock_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask : wr
  // One read; address held until taken
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clock_i);
    {arvalid_o, rready_o} <= 2'h3;
    araddr_o <= a;
    do @(posedge clock_i); while (arready_i !== 1'b1);
    arvalid_o <= 1'b0;
    araddr_o <= ~a;
    while (rvalid_i !== 1'b1) @(posedge clock_i);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask : rd
  // Parameters first, then opcode; poll until no longer busy
  task automatic cmd(input logic [7:0] op, f, c, lo, mid, hi);
    logic [1:0] r;
    logic [31:0] s;
    wr(sfd_pkg::ADR_FEATURE, {24'h0, f}, r);
    wr(sfd_pkg::ADR_SCOUNT, {24'h0, c}, r);
    wr(sfd_pkg::ADR_LBA_LO, {24'h0, lo}, r);
    wr(sfd_pkg::ADR_LBA_MID, {24'h0, mid}, r);
    wr(sfd_pkg::ADR_LBA_HI, {24'h0, hi}, r);
    wr(sfd_pkg::ADR_COMMAND, {24'h0, op}, r);
    n_cmd++;
    s = 32'h80;
    for (int i = 0; i < 8 && s[7]; i++) rd(sfd_pkg::ADR_STATUS, s, r);
  endtask : cmd
endmodule : sfd_host_model

/* verification/sfd_set_features_tb.sv */
// Self-checking bench for the set-features command decoder
`timescale 1ns/1ps
module sfd_set_features_tb;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, wc, la, su, bz;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdt, x;
  logic [1:0] bre, rre, r;
  int miscompares = 0;
  int n_tests = 0;
  int n_spin = 0;
  int n_busy = 0;
  always #12.5 clock_i = ~clock_i; // 40 MHz
  // Count spin-up pulses and busy cycles
  always @(posedge clock_i) n_spin += (su === 1'b1);
  always @(posedge clock_i) n_busy += (bz === 1'b1);
  sfd_set_features u_dut (.clock_i(clock_i), .srst_i(srst_i),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_bresp(bre), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdt),
    .s_axi_rresp(rre), .write_cache_on_o(wc), .look_ahead_on_o(la),
    .spin_up_o(su), .busy_o(bz));
  sfd_host_model u_host (.clock_i(clock_i), .awvalid_o(awv),
    .awready_i(awr), .awaddr_o(awa), .wvalid_o(wv), .wready_i(wrd),
    .wdata_o(wd), .bvalid_i(bv), .bready_o(br), .bresp_i(bre),
    .arvalid_o(arv), .arready_i(arr), .araddr_o(ara), .rvalid_i(rv),
    .rready_o(rr), .rdata_i(rdt), .rresp_i(rre));
  // Compare and count
  task automatic chk(input logic [31:0] s, e, input string m);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask : chk
  // Read a register and compare the masked bits
  task automatic rc(input logic [7:0] a, input logic [31:0] k, e,
                    input string m);
    u_host.rd(a, x, r);
    chk(x & k, e, m);
  endtask : rc
  task automatic fs(input logic [31:0] k, e, input string m);
    rc(sfd_pkg::ADR_FEAT_STATE, k, e, m);
  endtask : fs
  // Issue a command, check completion status and error
  task automatic cm(input logic [7:0] op, f, c, lo, mid, hi, st);
    u_host.cmd(op, f, c, lo, mid, hi);
    rc(sfd_pkg::ADR_STATUS, 32'hFF, {24'h0, st}, "status");
    rc(sfd_pkg::ADR_ERROR, 32'hFF, {29'h0, st[0], 2'h0}, "error");
  endtask : cm
  task automatic ef(input logic [7:0] f, c, st);
    cm(8'hEF, f, c, 8'h0, 8'h0, 8'h0, st);
  endtask : ef
  // Print the counts and the verdict
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    logic [7:0] bad[4] = '{8'h00, 8'h4A, 8'h01, 8'hFF};
    logic [15:0] ft[8] = '{16'h8202, 16'h0203, 16'h5501, 16'hAA03,
                           16'hCC07, 16'h6603, 16'h060B, 16'h8603};
    logic [23:0] xt[9] = '{24'h004000, 24'h014001, 24'h0C400C,
      24'h0D410C, 24'h224022, 24'h234122, 24'h464046, 24'h104146,
      24'h474146};
    logic [63:0] ap[9] = '{64'h0580_4002_0078_0000,
      64'h05BF_4002_01B3_0000, 64'h057F_4003_01B3_111C,
      64'h05FF_4103_01B3_111C, 64'h8500_4000_0000_0000,
      64'h053F_4003_0078_0258, 64'h0500_4103_0078_0258,
      64'h05C0_4001_0000_0000, 64'h0541_4003_0078_0294};
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    fs(32'hFF, 32'h03, "defaults");
    rc(sfd_pkg::ADR_XFER, 32'hFF, 32'h00, "xfer reset");
    chk({30'h0, wc, la}, 32'h3, "pins");
    $display("done: reset");
    foreach (bad[i]) begin
      ef(bad[i], 8'h0, 8'h41);
      fs(32'hFF, 32'h03, "no change");
    end
    cm(8'hEC, 8'h82, 8'h0, 8'h0, 8'h0, 8'h0, 8'h41);
    fs(32'hFF, 32'h03, "opcode");
    $display("done: aborts");
    foreach (ft[i]) begin
      ef(ft[i][15:8], 8'h0, 8'h40);
      fs(32'hFF, {24'h0, ft[i][7:0]}, "feature");
    end
    $display("done: features");
    foreach (xt[i]) begin
      ef(8'h03, xt[i][23:16], xt[i][15:8]);
      rc(sfd_pkg::ADR_XFER, 32'hFF, {24'h0, xt[i][7:0]}, "xfer");
    end
    $display("done: transfer");
    foreach (ap[i]) begin
      ef(ap[i][63:56], ap[i][55:48], ap[i][47:40]);
      rc(sfd_pkg::ADR_APM, 32'h300, {22'h0, ap[i][33:32], 8'h0}, "m");
      rc(sfd_pkg::ADR_DELAY1, 32'h1FF, {16'h0, ap[i][31:16]}, "d");
      rc(sfd_pkg::ADR_DELAY2, 32'h1FFF, {16'h0, ap[i][15:0]}, "d");
    end
    $display("done: power");
    for (int k = 1; k < 7; k++) begin
      ef(8'h10, 8'(k), (k == 5) ? 8'h41 : 8'h40);
      fs(32'h100 << k, (k == 5) ? 32'h0 : 32'h100 << k, "link on");
      ef(8'h90, 8'(k), (k == 5) ? 8'h41 : 8'h40);
      fs(32'h100 << k, 32'h0, "link off");
    end
    $display("done: link");
    u_host.wr(sfd_pkg::ADR_CONTROL, 32'h1, r);
    ef(8'h02, 8'h0, 8'h40);
    fs(32'h11, 32'h10, "forced off");
    chk({31'h0, wc}, 32'h0, "cache pin");
    u_host.wr(sfd_pkg::ADR_CONTROL, 32'h0, r);
    fs(32'h1, 32'h1, "cache back");
    chk({31'h0, wc}, 32'h1, "cache pin");
    ef(8'h07, 8'h0, 8'h41);
    ef(8'h06, 8'h0, 8'h40);
    u_host.wr(sfd_pkg::ADR_CONTROL, 32'h4, r);
    ef(8'h07, 8'h0, 8'h40);
    rc(sfd_pkg::ADR_CONTROL, 32'h4, 32'h0, "standby");
    ef(8'h07, 8'h0, 8'h40);
    chk(n_spin, 32'h1, "spin");
    $display("done: cache and spin-up");
    cm(8'hEF, 8'h43, 8'h34, 8'h12, 8'h78, 8'h56, 8'h40);
    rc(sfd_pkg::ADR_SECT_TIME, 32'hFFFFFFFF, 32'h56781234, "t");
    ef(8'h43, 8'h0, 8'h40);
    rc(sfd_pkg::ADR_SECT_TIME, 32'hFFFFFFFF, 32'h0, "zero");
    ef(8'h82, 8'h0, 8'h40);
    u_host.wr(sfd_pkg::ADR_CONTROL, 32'h2, r);
    fs(32'h3, 32'h2, "kept");
    rc(sfd_pkg::ADR_DELAY2, 32'h1FFF, 32'h294, "kept");
    ef(8'hCC, 8'h0, 8'h40);
    u_host.wr(sfd_pkg::ADR_CONTROL, 32'h2, r);
    fs(32'h3, 32'h3, "revert");
    rc(sfd_pkg::ADR_APM, 32'h300, 32'h0, "revert");
    rc(sfd_pkg::ADR_XFER, 32'hFF, 32'h0, "revert");
    u_host.rd(8'h3C, x, r);
    chk({x[29:0], r}, {30'h0, sfd_pkg::RESP_SLVERR}, "unmapped rd");
    u_host.wr(8'h3C, 32'h1, r);
    chk({30'h0, r}, {30'h0, sfd_pkg::RESP_SLVERR}, "unmapped wr");
    chk(n_busy, u_host.n_cmd, "busy cycles");
    $display("done: times, soft reset, bus");
    give_verdict();
  end
  // Watchdog, about eighteen times the expected run
  initial begin
    repeat (30000) @(posedge clock_i);
    miscompares++;
    give_verdict();
  end
endmodule : sfd_set_features_tb
